// ==== hw/digipot_pkg.sv ====
package digipot_pkg;

   localparam int WIPER_W = 8;
   localparam int CHANNELS = 2;
   localparam int STORE_AW = 5;
   localparam int STORE_DEPTH = 32;
   localparam int TIMER_W = 21;

   localparam logic [WIPER_W-1:0] MIDSCALE = 8'h80;
   localparam logic [WIPER_W-1:0] FULL_SCALE = 8'hFF;
   localparam logic [WIPER_W-1:0] ZERO_SCALE = 8'h00;
   localparam logic [WIPER_W-1:0] ONE_STEP = 8'h01;

   // Seven-bit bus address: fixed upper part, then the two select pins
   localparam logic [4:0] BUS_ADDR_FIXED = 5'h0B;

   // Instruction byte fields
   localparam int INSTR_CMD_BIT = 7;
   localparam int INSTR_STORE_BIT = 5;
   localparam int CMD_CODE_MSB = 6;
   localparam int CMD_CODE_LSB = 3;
   localparam int REG_ADDR_MSB = 4;
   localparam int CMD_CH_MSB = 2;

   // Channel addresses inside both wiper and store spaces
   localparam logic [2:0] CH0_CMD_ADDR = 3'h1;
   localparam logic [2:0] CH1_CMD_ADDR = 3'h3;
   localparam logic [STORE_AW-1:0] CH0_ADDR = 5'h01;
   localparam logic [STORE_AW-1:0] CH1_ADDR = 5'h03;

   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int RESTORE_TIME_NS = 300_000;
   localparam int PROGRAM_TIME_NS = 26_000_000;
   localparam int RESTORE_CYCLES = (RESTORE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   RESTORE_TIME_NS / CLK_PERIOD_NS;
   localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_RESTORE = 4'h1,
      CMD_STORE = 4'h2,
      CMD_HALF = 4'h3,
      CMD_HALF_ALL = 4'h4,
      CMD_DEC = 4'h5,
      CMD_DEC_ALL = 4'h6,
      CMD_RESTORE_ALL = 4'h7,
      CMD_DOUBLE = 4'h8,
      CMD_DOUBLE_ALL = 4'h9,
      CMD_INC = 4'hA,
      CMD_INC_ALL = 4'hB
   } cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESTORE = 2'b01,
      ST_PROGRAM = 2'b10
   } state_t;

endpackage

// ==== hw/digipot_sync.sv ====
`timescale 1ns/1ps
module digipot_sync #(
   parameter int W = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;

   // Resets low so a floating protect pin reads as protected
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= '0;
         o_q <= '0;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule

// ==== hw/digipot_timer.sv ====
`timescale 1ns/1ps
module digipot_timer #(
   parameter int W = 21
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [W-1:0] i_count,
   output logic o_done
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else if (i_start) begin
         cnt_q <= i_count;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   // Last cycle of the interval; no path from the start input back to done
   assign o_done = (cnt_q == W'(1));
endmodule

// ==== hw/digipot_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Wiper registers rewritable without limit, drive taps
// - Power-on loads wipers from nonvolatile store
// - Wipers start at midscale before restore
// - Restore takes about 300 microseconds
// - Store programming takes about 26 milliseconds
// - Direct store read leaves normal power
// - Code 2 stores addressed wiper
// - Code 1 restores addressed wiper
// - Code 7 restores all wipers
// - Codes 10/11 step up one/all
// - Codes 5/6 step down one/all
// - Codes 8/9 double one/all
// - Codes 3/4 halve one/all
// - Nine doublings from zero, eight halvings
// - Floating protect pin means protected
// - Protect pin high allows writes
// - Bus address 01011 plus select pins
// - Data line only pulled low, open drain
// - No address acknowledge while programming
// - Protection blocks writes, reads still work
// - Restore commands work under protection
// - Instruction MSB picks command or register
module digipot_ctrl
   import digipot_pkg::*;
#(
   parameter int RESTORE_CYCLES_P = digipot_pkg::RESTORE_CYCLES,
   parameter int PROGRAM_CYCLES_P = digipot_pkg::PROGRAM_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_wp_n,
   input wire logic i_addr_select_hi,
   input wire logic i_addr_select_lo,
   input wire logic i_addr_stb,
   input wire logic [7:0] i_addr_byte,
   input wire logic i_byte_stb,
   input wire logic [7:0] i_byte,
   input wire logic i_rd_stb,
   input wire logic i_stop,
   output logic o_ack,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic [digipot_pkg::WIPER_W-1:0] o_rd_data,
   output logic o_rd_valid,
   output logic [digipot_pkg::WIPER_W-1:0] o_wiper0,
   output logic [digipot_pkg::WIPER_W-1:0] o_wiper1,
   output logic o_busy,
   output logic o_store_read_active,
   output logic o_write_protected
);
   import digipot_pkg::*;

   logic [2:0] pins_s;
   logic wp_ok;
   logic boot_q;
   state_t state_q;
   state_t state_d;
   logic [CHANNELS-1:0] pend_q;
   logic [STORE_AW-1:0] prog_addr_q;
   logic [WIPER_W-1:0] prog_data_q;
   logic [WIPER_W-1:0] store_mem [STORE_DEPTH];
   logic sel_q;
   logic rd_mode_q;
   logic phase_q;
   logic [7:0] instr_q;
   logic [STORE_AW-1:0] ptr_q;
   logic timer_start;
   logic timer_done;
   logic addr_match;
   logic wr_byte;
   logic cmd_fire;
   logic data_fire;
   logic [3:0] code;
   logic [CHANNELS-1:0] ch_hit;
   logic [CHANNELS-1:0] op_mask;
   logic restore_go;
   logic prog_go;
   logic [STORE_AW-1:0] prog_addr_d;
   logic [WIPER_W-1:0] prog_data_d;
   logic [WIPER_W-1:0] rd_value;

   digipot_sync #(.W(3)) u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_d({i_wp_n, i_addr_select_hi, i_addr_select_lo}),
      .o_q(pins_s)
   );

   assign wp_ok = pins_s[2];

   digipot_timer #(.W(TIMER_W)) u_timer (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_start(timer_start),
      .i_count((state_d == ST_RESTORE) ? TIMER_W'(RESTORE_CYCLES_P) :
               TIMER_W'(PROGRAM_CYCLES_P)),
      .o_done(timer_done)
   );

   function automatic logic [WIPER_W-1:0] step_wiper(input logic [3:0] c,
                                                     input logic [WIPER_W-1:0] v);
      logic [WIPER_W-1:0] r;
      r = v;
      case (c)
         CMD_INC, CMD_INC_ALL: r = (v == FULL_SCALE) ? FULL_SCALE : v + ONE_STEP;
         CMD_DEC, CMD_DEC_ALL: r = (v == ZERO_SCALE) ? ZERO_SCALE : v - ONE_STEP;
         CMD_DOUBLE, CMD_DOUBLE_ALL: begin
            // Zero goes to one, top bit set goes to full scale
            if (v == ZERO_SCALE) begin
               r = ONE_STEP;
            end else if (v[WIPER_W-1]) begin
               r = FULL_SCALE;
            end else begin
               r = {v[WIPER_W-2:0], 1'b0};
            end
         end
         CMD_HALF, CMD_HALF_ALL: r = {1'b0, v[WIPER_W-1:1]};
         default: r = v;
      endcase
      return r;
   endfunction

   // Bus side decode
   assign addr_match = (i_addr_byte[7:1] == {BUS_ADDR_FIXED, pins_s[1], pins_s[0]});
   assign wr_byte = i_byte_stb && sel_q && !rd_mode_q;
   assign cmd_fire = wr_byte && !phase_q && i_byte[INSTR_CMD_BIT];
   assign data_fire = wr_byte && phase_q && !instr_q[INSTR_CMD_BIT];
   assign code = i_byte[CMD_CODE_MSB:CMD_CODE_LSB];
   assign ch_hit = {i_byte[CMD_CH_MSB:0] == CH1_CMD_ADDR, i_byte[CMD_CH_MSB:0] == CH0_CMD_ADDR};

   always_comb begin
      op_mask = '0;
      case (code)
         CMD_HALF, CMD_DEC, CMD_DOUBLE, CMD_INC: op_mask = ch_hit;
         CMD_HALF_ALL, CMD_DEC_ALL, CMD_DOUBLE_ALL, CMD_INC_ALL: op_mask = '1;
         default: op_mask = '0;
      endcase
      if (!cmd_fire || !wp_ok) begin
         op_mask = '0;
      end
   end

   // Restore is allowed regardless of protection
   assign restore_go = cmd_fire && ((code == CMD_RESTORE && ch_hit != '0) ||
                                    code == CMD_RESTORE_ALL);

   always_comb begin
      prog_go = 1'b0;
      prog_addr_d = ptr_q;
      prog_data_d = i_byte;
      if (data_fire && instr_q[INSTR_STORE_BIT] && wp_ok) begin
         prog_go = 1'b1;
      end else if (cmd_fire && code == CMD_STORE && ch_hit != '0 && wp_ok) begin
         prog_go = 1'b1;
         prog_addr_d = ch_hit[1] ? CH1_ADDR : CH0_ADDR;
         prog_data_d = ch_hit[1] ? o_wiper1 : o_wiper0;
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (boot_q || restore_go) begin
               state_d = ST_RESTORE;
            end else if (prog_go) begin
               state_d = ST_PROGRAM;
            end
         end
         ST_RESTORE: begin
            if (timer_done) begin
               state_d = ST_IDLE;
            end
         end
         ST_PROGRAM: begin
            if (timer_done) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   assign timer_start = (state_q == ST_IDLE) && (state_d != ST_IDLE);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         boot_q <= 1'b1;
         state_q <= ST_IDLE;
         o_busy <= 1'b0;
      end else begin
         boot_q <= 1'b0;
         state_q <= state_d;
         o_busy <= (state_d != ST_IDLE);
      end
   end

   // Channels waiting for a restore
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pend_q <= '1;
      end else if (state_q == ST_IDLE && restore_go) begin
         pend_q <= (code == CMD_RESTORE_ALL) ? '1 : ch_hit;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         prog_addr_q <= '0;
         prog_data_q <= '0;
      end else if (state_q == ST_IDLE && prog_go) begin
         prog_addr_q <= prog_addr_d;
         prog_data_q <= prog_data_d;
      end
   end

   // Erase and write land together at the end of the program interval
   always_ff @(posedge i_ref_clk) begin
      if (state_q == ST_PROGRAM && timer_done) begin
         store_mem[prog_addr_q] <= prog_data_q;
      end
   end

   // Wiper registers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wiper0 <= MIDSCALE;
         o_wiper1 <= MIDSCALE;
      end else if (state_q == ST_RESTORE && timer_done) begin
         if (pend_q[0]) begin
            o_wiper0 <= store_mem[CH0_ADDR];
         end
         if (pend_q[1]) begin
            o_wiper1 <= store_mem[CH1_ADDR];
         end
      end else if (data_fire && !instr_q[INSTR_STORE_BIT] && wp_ok) begin
         if (ptr_q == CH0_ADDR) begin
            o_wiper0 <= i_byte;
         end
         if (ptr_q == CH1_ADDR) begin
            o_wiper1 <= i_byte;
         end
      end else begin
         if (op_mask[0]) begin
            o_wiper0 <= step_wiper(code, o_wiper0);
         end
         if (op_mask[1]) begin
            o_wiper1 <= step_wiper(code, o_wiper1);
         end
      end
   end

   // Transaction tracking
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_q <= 1'b0;
         rd_mode_q <= 1'b0;
         phase_q <= 1'b0;
         instr_q <= '0;
         ptr_q <= '0;
      end else if (i_addr_stb) begin
         sel_q <= addr_match && state_q == ST_IDLE && !boot_q;
         rd_mode_q <= i_addr_byte[0];
         phase_q <= 1'b0;
      end else if (i_stop) begin
         sel_q <= 1'b0;
      end else if (wr_byte && !phase_q) begin
         instr_q <= i_byte;
         phase_q <= 1'b1;
         if (!i_byte[INSTR_CMD_BIT]) begin
            ptr_q <= i_byte[REG_ADDR_MSB:0];
         end
      end else if (data_fire || (i_rd_stb && sel_q && rd_mode_q)) begin
         ptr_q <= ptr_q + STORE_AW'(1);
      end
   end

   // Acknowledge and open-drain data line
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         o_sda_o <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         o_ack <= (i_addr_stb && addr_match && state_q == ST_IDLE && !boot_q) || wr_byte;
         o_sda_oe <= (i_addr_stb && addr_match && state_q == ST_IDLE && !boot_q) ||
                     wr_byte;
         o_sda_o <= 1'b0;
      end
   end

   always_comb begin
      rd_value = ZERO_SCALE;
      if (instr_q[INSTR_STORE_BIT]) begin
         rd_value = store_mem[ptr_q];
      end else if (ptr_q == CH0_ADDR) begin
         rd_value = o_wiper0;
      end else if (ptr_q == CH1_ADDR) begin
         rd_value = o_wiper1;
      end
   end

   // Reads work under protection
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= '0;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_stb && sel_q && rd_mode_q;
         if (i_rd_stb && sel_q && rd_mode_q) begin
            o_rd_data <= rd_value;
         end
      end
   end

   // Store read power state after a code 1 restore command (code 7 leaves it unchanged)
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_store_read_active <= 1'b0;
         o_write_protected <= 1'b1;
      end else begin
         o_write_protected <= !wp_ok;
         if (cmd_fire && code == CMD_RESTORE && ch_hit != '0) begin
            o_store_read_active <= 1'b1;
         end else if (cmd_fire && code == CMD_NOP) begin
            o_store_read_active <= 1'b0;
         end
      end
   end

   // Helper: cycles spent in a busy state
   logic [TIMER_W-1:0] stay_q;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         stay_q <= '0;
      end else if (state_q == ST_IDLE) begin
         stay_q <= '0;
      end else begin
         stay_q <= stay_q + TIMER_W'(1);
      end
   end

   boot_mid_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      boot_q |-> (o_wiper0 == MIDSCALE && o_wiper1 == MIDSCALE))
      else $error("wipers not midscale at boot");

   boot_restore_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      boot_q |=> (state_q == ST_RESTORE) [*2])
      else $error("no restore after power-on");

   restore_time_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_q == ST_RESTORE && timer_done) |-> stay_q == TIMER_W'(RESTORE_CYCLES_P - 1))
      else $error("restore interval wrong");

   program_time_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_q == ST_PROGRAM && timer_done) |-> stay_q == TIMER_W'(PROGRAM_CYCLES_P - 1))
      else $error("program interval wrong");

   busy_nack_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_addr_stb && state_q != ST_IDLE) |=> !o_ack && !o_sda_oe)
      else $error("acknowledged while busy");

   protect_wr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (data_fire && !wp_ok && state_q == ST_IDLE) |=> $stable(o_wiper0) && $stable(o_wiper1))
      else $error("wiper written under protection");

   inc_sat_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (cmd_fire && wp_ok && code == CMD_INC_ALL) |=>
      o_wiper0 == (($past(o_wiper0) == FULL_SCALE) ? FULL_SCALE : $past(o_wiper0) + ONE_STEP))
      else $error("increment wrong");

   halve_all_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (cmd_fire && wp_ok && code == CMD_HALF_ALL) |=>
      o_wiper1 == {1'b0, $past(o_wiper1[WIPER_W-1:1])})
      else $error("halving wrong");

   restore_power_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (cmd_fire && code == CMD_RESTORE && ch_hit != '0) |=> o_store_read_active ##1 o_busy)
      else $error("restore command state wrong");

   sda_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_sda_oe |-> !o_sda_o && $past(i_addr_stb || i_byte_stb))
      else $error("data line driven without cause");

   restore_cmd_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      restore_go && !wp_ok);
   program_done_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      state_q == ST_PROGRAM && timer_done);
   read_back_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
      o_rd_valid);
endmodule

// ==== dv/digipot_master.sv ====
`timescale 1ns/1ps
module digipot_master (
   input wire logic i_ref_clk,
   input wire logic i_ack,
   input wire logic [7:0] i_rd_data,
   output logic o_addr_stb,
   output logic [7:0] o_addr_byte,
   output logic o_byte_stb,
   output logic [7:0] o_byte,
   output logic o_rd_stb,
   output logic o_stop
);
   initial begin
      o_addr_stb = 1'b0;
      o_addr_byte = 8'h00;
      o_byte_stb = 1'b0;
      o_byte = 8'h00;
      o_rd_stb = 1'b0;
      o_stop = 1'b0;
   end

   // Kind 0 address, 1 write byte, 2 read byte, 3 stop
   task automatic pulse(input int kind, input logic [7:0] b, output logic ack,
                        output logic [7:0] rd);
      @(posedge i_ref_clk);
      #1;
      o_addr_byte = b;
      o_byte = b;
      o_addr_stb = (kind == 0);
      o_byte_stb = (kind == 1);
      o_rd_stb = (kind == 2);
      o_stop = (kind == 3);
      @(posedge i_ref_clk);
      #1;
      o_addr_stb = 1'b0;
      o_byte_stb = 1'b0;
      o_rd_stb = 1'b0;
      o_stop = 1'b0;
      // Released lanes show no stale value
      o_addr_byte = ~b;
      o_byte = ~b;
      ack = i_ack;
      rd = i_rd_data;
   endtask

   // Address until acknowledged, stop between tries
   task automatic poll(input logic [7:0] dev, output int tries);
      logic ack;
      logic nak;
      logic [7:0] d;
      ack = 1'b0;
      tries = 0;
      while (ack !== 1'b1 && tries < 200) begin
         pulse(0, dev, ack, d);
         tries++;
         if (ack !== 1'b1) begin
            pulse(3, 8'h00, nak, d);
         end
      end
   endtask

   task automatic quick(input logic [7:0] dev, input logic [7:0] instr, output int tries);
      logic ack;
      logic [7:0] d;
      poll(dev, tries);
      pulse(1, instr, ack, d);
      pulse(3, 8'h00, ack, d);
   endtask

   // No-op after a restore drops the store back to idle power
   task automatic idle_after_restore(input logic [7:0] dev, output int tries);
      quick(dev, 8'h80, tries);
   endtask
endmodule

// ==== dv/digipot_command_control_test.sv ====
`timescale 1ns/1ps
module digipot_command_control_test;
   import digipot_pkg::*;
   localparam int RC = 10;
   localparam int PC = 20;
   localparam logic [7:0] DEV_W = {BUS_ADDR_FIXED, 3'b000};
   logic clk, rst, wp_n, sel_hi, sel_lo, addr_stb, byte_stb, rd_stb, stop;
   logic ack, sda_o, sda_oe, rd_valid, busy, store_rd, wprot;
   logic [7:0] addr_byte, wbyte, rd_data, wiper0, wiper1;
   int error_cnt = 0;
   int n_tests = 0;

   digipot_ctrl #(.RESTORE_CYCLES_P(RC), .PROGRAM_CYCLES_P(PC)) i_dut (
      .i_ref_clk(clk), .i_rst(rst), .i_wp_n(wp_n), .i_addr_select_hi(sel_hi),
      .i_addr_select_lo(sel_lo), .i_addr_stb(addr_stb), .i_addr_byte(addr_byte),
      .i_byte_stb(byte_stb), .i_byte(wbyte), .i_rd_stb(rd_stb), .i_stop(stop),
      .o_ack(ack), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_rd_data(rd_data),
      .o_rd_valid(rd_valid), .o_wiper0(wiper0), .o_wiper1(wiper1), .o_busy(busy),
      .o_store_read_active(store_rd), .o_write_protected(wprot));
   digipot_master i_master (
      .i_ref_clk(clk), .i_ack(ack), .i_rd_data(rd_data), .o_addr_stb(addr_stb),
      .o_addr_byte(addr_byte), .o_byte_stb(byte_stb), .o_byte(wbyte),
      .o_rd_stb(rd_stb), .o_stop(stop));

   always #10 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Checks %0d, errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic tmo(input int t);
      if (t >= 200) begin
         check("poll ack", 0, 1);
         wrap_up();
      end
   endtask

   task automatic wait_idle(output int n);
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      tmo(n / 10);
   endtask

   task automatic set_pins(input logic wp, input logic hi, input logic lo);
      wp_n = wp;
      sel_hi = hi;
      sel_lo = lo;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic cmd(input logic [7:0] instr);
      int t;
      i_master.quick(DEV_W, instr, t);
      tmo(t);
   endtask

   task automatic wr_reg(input logic [7:0] instr, input logic [7:0] data);
      int t;
      logic a;
      logic [7:0] d;
      i_master.poll(DEV_W, t);
      tmo(t);
      i_master.pulse(1, instr, a, d);
      i_master.pulse(1, data, a, d);
      i_master.pulse(3, 8'h00, a, d);
   endtask

   task automatic rd_reg(input logic [7:0] instr, output logic [7:0] d);
      int t;
      logic a;
      cmd(instr);
      i_master.poll(DEV_W | 8'h01, t);
      tmo(t);
      i_master.pulse(2, 8'h00, a, d);
      check("rd valid", rd_valid, 1'b1);
      i_master.pulse(3, 8'h00, a, d);
   endtask

   function automatic logic [7:0] step(input logic [3:0] c, input logic [7:0] v);
      case (c)
         4'h3, 4'h4: step = v >> 1;
         4'h5, 4'h6: step = (v == 8'h00) ? 8'h00 : v - 8'h01;
         4'h8, 4'h9: step = (v == 8'h00) ? 8'h01 : (v[7] ? 8'hFF : {v[6:0], 1'b0});
         default: step = (v == 8'hFF) ? 8'hFF : v + 8'h01;
      endcase
   endfunction

   task automatic t_boot();
      int n;
      logic a;
      logic [7:0] d;
      repeat (8) @(posedge clk);
      #1;
      check("reset wiper0", wiper0, MIDSCALE);
      check("protected", wprot, 1'b1);
      rst = 1'b0;
      @(posedge clk);
      #1;
      check("boot busy", busy, 1'b1);
      check("boot wiper1", wiper1, MIDSCALE);
      i_master.pulse(0, DEV_W, a, d);
      check("boot ack", a, 1'b0);
      wait_idle(n);
      check("boot length", n >= RC - 5 && n <= RC + 1, 1'b1);
   endtask

   task automatic t_address();
      logic a;
      logic [7:0] d;
      for (int s = 0; s < 4; s++) begin
         set_pins(1'b1, s[1], s[0]);
         i_master.pulse(0, {BUS_ADDR_FIXED, s[1:0], 1'b0}, a, d);
         check("own addr", a, 1'b1);
         check("sda pull", {sda_oe, sda_o}, 2'b10);
         i_master.pulse(0, {BUS_ADDR_FIXED, ~s[1:0], 1'b0}, a, d);
         check("other sel", a, 1'b0);
         check("sda free", sda_oe, 1'b0);
         i_master.pulse(0, {5'h0A, s[1:0], 1'b0}, a, d);
         check("other fixed", a, 1'b0);
         i_master.pulse(3, 8'h00, a, d);
      end
      set_pins(1'b1, 1'b0, 1'b0);
   endtask

   task automatic t_protect();
      logic [7:0] d;
      wr_reg(8'h01, 8'h40);
      wr_reg(8'h03, 8'hC3);
      wr_reg(8'h01, 8'h41);
      check("rewrite", wiper0, 8'h41);
      check("wiper1", wiper1, 8'hC3);
      check("unprot", wprot, 1'b0);
      set_pins(1'b0, 1'b0, 1'b0);
      check("prot flag", wprot, 1'b1);
      wr_reg(8'h01, 8'h55);
      cmd(8'hD8);
      check("blocked", wiper0, 8'h41);
      rd_reg(8'h03, d);
      check("prot read", d, 8'hC3);
      set_pins(1'b1, 1'b0, 1'b0);
   endtask

   task automatic t_quick();
      logic [3:0] codes [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB};
      logic [7:0] w0, w1;
      logic all;
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 8; k++) begin
            w0 = p ? 8'h81 : 8'h00;
            w1 = p ? 8'h01 : 8'hFF;
            wr_reg(8'h01, w0);
            wr_reg(8'h03, w1);
            cmd({1'b1, codes[k], p ? 3'h3 : 3'h1});
            all = codes[k] inside {4'h4, 4'h6, 4'h9, 4'hB};
            check("q wiper0", wiper0, (all || p == 0) ? step(codes[k], w0) : w0);
            check("q wiper1", wiper1, (all || p == 1) ? step(codes[k], w1) : w1);
         end
      end
   endtask

   task automatic t_limits();
      wr_reg(8'h01, 8'h00);
      for (int i = 0; i < 9; i++) begin
         cmd(8'hC1);
      end
      check("nine doublings", wiper0, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         cmd(8'h99);
      end
      check("eight halvings", wiper0, 8'h00);
      cmd(8'hE1);
      check("reserved code", wiper0, 8'h00);
   endtask

   task automatic t_store();
      int n;
      logic [7:0] d;
      wr_reg(8'h01, 8'h3C);
      cmd(8'h91);
      check("store busy", busy, 1'b1);
      wait_idle(n);
      check("program len", n >= PC - 3 && n <= PC + 1, 1'b1);
      wr_reg(8'h23, 8'h5A);
      i_master.poll(DEV_W, n);
      tmo(n);
      check("polls", n > 1, 1'b1);
      rd_reg(8'h21, d);
      check("store read", d, 8'h3C);
      check("no idle need", store_rd, 1'b0);
      wr_reg(8'h01, 8'h77);
      cmd(8'h89);
      check("restore flag", store_rd, 1'b1);
      wait_idle(n);
      check("restore len", n >= RC - 3 && n <= RC + 1, 1'b1);
      check("restored", wiper0, 8'h3C);
      i_master.idle_after_restore(DEV_W, n);
      check("flag idle", store_rd, 1'b0);
      wr_reg(8'h01, 8'h01);
      wr_reg(8'h03, 8'h02);
      set_pins(1'b0, 1'b0, 1'b0);
      cmd(8'h93);
      check("store blocked", busy, 1'b0);
      cmd(8'hB9);
      wait_idle(n);
      check("all wiper0", wiper0, 8'h3C);
      check("all wiper1", wiper1, 8'h5A);
      set_pins(1'b1, 1'b0, 1'b0);
   endtask

   task automatic t_power();
      int n;
      wr_reg(8'h01, 8'h11);
      rst = 1'b1;
      @(posedge clk);
      #1;
      check("midscale", wiper0, MIDSCALE);
      rst = 1'b0;
      @(posedge clk);
      #1;
      check("power busy", busy, 1'b1);
      wait_idle(n);
      check("power wiper0", wiper0, 8'h3C);
      check("power wiper1", wiper1, 8'h5A);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      wp_n = 1'b0;
      sel_hi = 1'b0;
      sel_lo = 1'b0;
      t_boot();
      t_address();
      t_protect();
      t_quick();
      t_limits();
      t_store();
      t_power();
      wrap_up();
   end
endmodule
